// file: phy_util_map.svh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * utility bus and status pin block.
 * Assumes it is included by its bare name wherever the values are needed.
 */
`ifndef PHY_UTIL_MAP_SVH
`define PHY_UTIL_MAP_SVH

`define REF_PORT_CONFIG_ADDR   8'h40
`define MARKER_LENGTH_ADDR     8'h41
`define INT_STATUS_ADDR        8'h42
`define INT_MASK_ADDR          8'h43
`define LINE_STATUS_ADDR       8'h44

`define REF_PORT_LSB           0
`define REF_PORT_MSB           1
`define LINE_RATE_64_BIT       0

`define REF_PORT_CONFIG_RESET  8'h00
`define MARKER_LENGTH_RESET    8'h01
`define INT_MASK_RESET         4'h0

`define UNMAPPED_READ_VALUE    8'h00

// Lamp on time is 2^23 line clock cycles
`define LAMP_CYCLES            24'h800000
`define LAMP_CNT_W             24

`endif

// file: phy_util_pkg.sv
/*
 * Types shared by the utility bus and status pin block.
 * Assumes phy_util_map.svh holds the numeric values.
 */
package phy_util_pkg;

	typedef struct packed {
		logic       ale;
		logic       cs_n;
		logic       rd_n;
		logic       wr_n;
		logic [7:0] ad;
	} bus_pins_type;

	typedef enum logic [1:0] {
		BUS_IDLE,
		BUS_READ,
		BUS_WRITE
	} bus_state_type;

endpackage : phy_util_pkg

// file: phy_util_port.sv
/*
 * Utility bus register port and status pins of a four port line device:
 * multiplexed address/data host bus, open-drain interrupt, receive lamps,
 * receive timing marker and line rate indication.
 * Assumes every host strobe is asynchronous to MCLK_IN, while cell start,
 * good cell, timing command and interrupt source inputs are on MCLK_IN.
 */
`timescale 1ns/10ps
`include "phy_util_map.svh"

module phy_util_port (
	input  wire logic       MCLK_IN,
	input  wire logic       RESET_N_IN,
	input  wire logic [7:0] AD_IN,
	output logic      [7:0] AD_OUT,
	output logic            AD_OE_OUT,
	input  wire logic       ALE_IN,
	input  wire logic       CS_N_IN,
	input  wire logic       RD_N_IN,
	input  wire logic       WR_N_IN,
	output logic            INT_N_OUT,
	output logic            INT_N_OE_OUT,
	input  wire logic [3:0] INT_SOURCE_IN,
	input  wire logic       RATE_64_IN,
	input  wire logic [3:0] RX_CELL_START_IN,
	input  wire logic [3:0] RX_GOOD_CELL_IN,
	input  wire logic [3:0] RX_TIMING_CMD_IN,
	output logic      [3:0] RX_ACTIVITY_LAMP_N_OUT,
	output logic            RX_TIMING_MARKER_N_OUT
);

	phy_util_pkg::bus_pins_type  pins_meta_r;
	phy_util_pkg::bus_pins_type  pins_r;
	phy_util_pkg::bus_pins_type  pins_prev_r;
	phy_util_pkg::bus_state_type state_r;
	logic                        rst_meta_r;
	logic                        rst_n_r;
	logic [7:0]                  addr_r;
	logic [7:0]                  wr_data_r;
	logic [7:0]                  ref_cfg_r;
	logic [7:0]                  marker_len_r;
	logic [3:0]                  int_status_r;
	logic [3:0]                  int_mask_r;
	logic                        rate_64_r;
	logic [7:0]                  marker_cnt_r;
	logic                        read_on;
	logic                        write_on;
	logic                        write_done;
	logic                        status_read_done;
	logic [1:0]                  ref_port;

	function automatic logic [7:0] read_mux(
		input logic [7:0] addr,
		input logic [7:0] ref_cfg,
		input logic [7:0] marker_len,
		input logic [3:0] status,
		input logic [3:0] mask,
		input logic       rate_64
	);
		logic [7:0] val;
		val = `UNMAPPED_READ_VALUE;
		unique case (addr)
			`REF_PORT_CONFIG_ADDR: val = ref_cfg;
			`MARKER_LENGTH_ADDR:   val = marker_len;
			`INT_STATUS_ADDR:      val = {4'h0, status};
			`INT_MASK_ADDR:        val = {4'h0, mask};
			`LINE_STATUS_ADDR:     val = {7'h00, rate_64};
			default:               val = `UNMAPPED_READ_VALUE;
		endcase
		return val;
	endfunction : read_mux

	// Reset release passes two flops; the second one resets the block
	always_ff @(posedge MCLK_IN)
	begin
		rst_meta_r <= RESET_N_IN;
		rst_n_r    <= rst_meta_r;
	end

	// Host pins are asynchronous: two flops before any logic reads them
	always_ff @(posedge MCLK_IN)
	begin
		pins_meta_r <= {ALE_IN, CS_N_IN, RD_N_IN, WR_N_IN, AD_IN};
		pins_r      <= pins_meta_r;
		pins_prev_r <= pins_r;
	end

	assign read_on  = !pins_r.cs_n && !pins_r.rd_n && pins_r.wr_n;
	assign write_on = !pins_r.cs_n && !pins_r.wr_n && pins_r.rd_n;
	// Write ends at the first of WR or CS going high
	assign write_done = (state_r == phy_util_pkg::BUS_WRITE) && !write_on;
	assign status_read_done = (state_r == phy_util_pkg::BUS_READ) && !read_on
		&& (addr_r == `INT_STATUS_ADDR);
	assign ref_port = ref_cfg_r[`REF_PORT_MSB:`REF_PORT_LSB];

	// ALE low during data keeps the latched address stable
	always_ff @(posedge MCLK_IN)
	begin
		if (!rst_n_r)
			addr_r <= 8'h00;
		else if (pins_prev_r.ale && !pins_r.ale)
			addr_r <= pins_prev_r.ad;
	end

	always_ff @(posedge MCLK_IN)
	begin
		if (!rst_n_r)
			state_r <= phy_util_pkg::BUS_IDLE;
		else
		begin
			unique case (state_r)
				phy_util_pkg::BUS_IDLE:
					if (read_on)
						state_r <= phy_util_pkg::BUS_READ;
					else if (write_on)
						state_r <= phy_util_pkg::BUS_WRITE;
				phy_util_pkg::BUS_READ:
					if (!read_on)
						state_r <= phy_util_pkg::BUS_IDLE;
				phy_util_pkg::BUS_WRITE:
					if (!write_on)
						state_r <= phy_util_pkg::BUS_IDLE;
				// The unused fourth code returns to idle
				default:
					state_r <= phy_util_pkg::BUS_IDLE;
			endcase
		end
	end

	// Data follows the pins while the strobe is low; last value is kept
	always_ff @(posedge MCLK_IN)
	begin
		if (!rst_n_r)
			wr_data_r <= 8'h00;
		else if (write_on)
			wr_data_r <= pins_r.ad;
	end

	always_ff @(posedge MCLK_IN)
	begin
		if (!rst_n_r)
		begin
			ref_cfg_r    <= `REF_PORT_CONFIG_RESET;
			marker_len_r <= `MARKER_LENGTH_RESET;
			int_mask_r   <= `INT_MASK_RESET;
		end
		else if (write_done)
		begin
			if (addr_r == `REF_PORT_CONFIG_ADDR)
				ref_cfg_r <= wr_data_r;
			if (addr_r == `MARKER_LENGTH_ADDR)
				marker_len_r <= wr_data_r;
			if (addr_r == `INT_MASK_ADDR)
				int_mask_r <= wr_data_r[3:0];
		end
	end

	// Read data is driven only for a read in progress
	always_ff @(posedge MCLK_IN)
	begin
		if (!rst_n_r)
		begin
			AD_OUT    <= 8'h00;
			AD_OE_OUT <= 1'b0;
		end
		else
		begin
			AD_OUT    <= read_mux(addr_r, ref_cfg_r, marker_len_r,
				int_status_r, int_mask_r, rate_64_r);
			AD_OE_OUT <= read_on;
		end
	end

	// Sticky sources; a new event beats the clear at read completion
	always_ff @(posedge MCLK_IN)
	begin
		if (!rst_n_r)
			int_status_r <= 4'h0;
		else if (status_read_done)
			int_status_r <= INT_SOURCE_IN;
		else
			int_status_r <= int_status_r | INT_SOURCE_IN;
	end

	// Open drain: low is driven, high is released
	always_ff @(posedge MCLK_IN)
	begin
		if (!rst_n_r)
		begin
			INT_N_OUT    <= 1'b0;
			INT_N_OE_OUT <= 1'b0;
		end
		else
		begin
			INT_N_OUT    <= 1'b0;
			INT_N_OE_OUT <= |(int_status_r & int_mask_r);
		end
	end

	// Rate strap caught while the block is held in reset
	always_ff @(posedge MCLK_IN)
	begin
		if (!rst_n_r)
			rate_64_r <= RATE_64_IN;
	end

	generate
		for (genvar p = 0; p < 4; p++)
		begin : lamp_gen
			logic [`LAMP_CNT_W-1:0] cnt_r;
			always_ff @(posedge MCLK_IN)
			begin
				if (!rst_n_r)
				begin
					cnt_r                     <= '0;
					RX_ACTIVITY_LAMP_N_OUT[p] <= 1'b1;
				end
				else if (RX_CELL_START_IN[p] && RX_GOOD_CELL_IN[p])
				begin
					cnt_r                     <= `LAMP_CYCLES - 24'h000001;
					RX_ACTIVITY_LAMP_N_OUT[p] <= 1'b0;
				end
				else if (cnt_r != '0)
					cnt_r <= cnt_r - 24'h000001;
				else
					RX_ACTIVITY_LAMP_N_OUT[p] <= 1'b1;
			end
		end
	endgenerate

	// Zero length still gives a one cycle marker
	always_ff @(posedge MCLK_IN)
	begin
		if (!rst_n_r)
		begin
			marker_cnt_r           <= 8'h00;
			RX_TIMING_MARKER_N_OUT <= 1'b1;
		end
		else if (RX_TIMING_CMD_IN[ref_port])
		begin
			marker_cnt_r <= (marker_len_r == 8'h00) ? 8'h00
				: marker_len_r - 8'h01;
			RX_TIMING_MARKER_N_OUT <= 1'b0;
		end
		else if (marker_cnt_r != 8'h00)
			marker_cnt_r <= marker_cnt_r - 8'h01;
		else
			RX_TIMING_MARKER_N_OUT <= 1'b1;
	end

endmodule : phy_util_port

// file: phy_util_host.sv
/* Host processor model on the multiplexed utility bus.
 * Assumes the bench calls wr and rd from one process. */
`timescale 1ns/10ps
module phy_util_host (
	input  wire logic                  clk_in,
	input  wire logic                  oe_in,
	input  wire logic [7:0]            ad_in,
	output phy_util_pkg::bus_pins_type pins_out,
	output logic      [7:0]            rd_data_out,
	output logic                       rd_valid_out
);
	logic       ale_r = 1'h0, cs_r = 1'h1, rd_r = 1'h1, wr_r = 1'h1;
	logic       drv_r = 1'h0;
	logic [7:0] ad_r  = 8'h00;
	initial rd_valid_out = 1'h0;
	// A released bus shows the inverse of the last driven value
	assign pins_out = {ale_r, cs_r, rd_r, wr_r,
		oe_in ? ad_in : drv_r ? ad_r : ~ad_r};
	task adr(input logic [7:0] a);
		@(negedge clk_in);
		{drv_r, ad_r, ale_r} = {1'h1, a, 1'h1};
		repeat (3) @(negedge clk_in);
		ale_r = 1'h0;
		repeat (3) @(negedge clk_in);
	endtask : adr
	task wr(input logic [7:0] a, d, input logic c);
		adr(a);
		ad_r = d;
		{rd_r, wr_r, cs_r} = {1'h1, 1'h0, c};
		repeat (6) @(negedge clk_in);
		{wr_r, cs_r} = 2'h3;
		@(negedge clk_in);
		drv_r = 1'h0;
		repeat (4) @(negedge clk_in);
	endtask : wr
	task rd(input logic [7:0] a, output logic ok);
		int i;
		adr(a);
		{drv_r, wr_r, rd_r, cs_r, ok} = 5'h08;
		for (i = 0; i < 20 && !ok; i++)
			@(posedge clk_in) {ok, rd_data_out} = {oe_in, ad_in};
		@(negedge clk_in);
		{rd_valid_out, rd_r, cs_r} = {ok, 2'h3};
		@(negedge clk_in);
		rd_valid_out = 1'h0;
		repeat (6) @(negedge clk_in);
	endtask : rd
endmodule : phy_util_host

// file: phy_util_port_monitor.sv
/* Assertions on the utility bus port pins.
 * Assumes it is bound to phy_util_port. */
`timescale 1ns/10ps
module phy_util_port_monitor (
	input wire logic       MCLK_IN,
	input wire logic       RESET_N_IN,
	input wire logic       CS_N_IN,
	input wire logic       RD_N_IN,
	input wire logic       WR_N_IN,
	input wire logic       AD_OE_OUT,
	input wire logic       INT_N_OUT,
	input wire logic       INT_N_OE_OUT,
	input wire logic [3:0] INT_SOURCE_IN,
	input wire logic [3:0] RX_CELL_START_IN,
	input wire logic [3:0] RX_GOOD_CELL_IN,
	input wire logic [3:0] RX_TIMING_CMD_IN,
	input wire logic [3:0] RX_ACTIVITY_LAMP_N_OUT,
	input wire logic       RX_TIMING_MARKER_N_OUT
);
	default clocking @(posedge MCLK_IN); endclocking
	default disable iff (!RESET_N_IN);
	// Pins reach the enable three sampling edges before its change is seen
	oe_rise_a:
	assert property ($rose(AD_OE_OUT) |->
		$past(!CS_N_IN && !RD_N_IN && WR_N_IN, 3)) else $error("oe rise");
	oe_fall_a:
	assert property ($fell(AD_OE_OUT) |->
		$past(RD_N_IN || CS_N_IN || !WR_N_IN, 3)) else $error("oe fall");
	int_data_a:
	assert property (INT_N_OUT == 1'h0) else $error("int data");
	int_cause_a:
	assert property ($rose(INT_N_OE_OUT) |-> $past(|INT_SOURCE_IN, 2))
		else $error("int cause");
	lamp_on_a:
	assert property (RX_CELL_START_IN[3] && RX_GOOD_CELL_IN[3] |->
		##[1:2] !RX_ACTIVITY_LAMP_N_OUT[3]) else $error("lamp on");
	lamp_cause_a:
	assert property ($fell(RX_ACTIVITY_LAMP_N_OUT[3]) |->
		$past(RX_GOOD_CELL_IN[3], 1) || $past(RX_GOOD_CELL_IN[3], 2))
		else $error("lamp cause");
	lamp_hold_a:
	assert property ($fell(RX_ACTIVITY_LAMP_N_OUT[3]) |->
		!RX_ACTIVITY_LAMP_N_OUT[3] [*8]) else $error("lamp hold");
	mark_cause_a:
	assert property ($fell(RX_TIMING_MARKER_N_OUT) |->
		$past(|RX_TIMING_CMD_IN, 1) || $past(|RX_TIMING_CMD_IN, 2))
		else $error("marker cause");
endmodule : phy_util_port_monitor
bind phy_util_port phy_util_port_monitor phy_util_port_monitor_i (.*);

// file: phy_util_port_tb_top.sv
/* Bench for phy_util_port: host model, read queue, pin checks.
 * Assumes phy_util_host drives the utility bus. */
`timescale 1ns/10ps
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin err_count++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, g, e); end end
module phy_util_port_tb_top;
	logic        clk = 1'h0, rst_n = 1'h0, rate = 1'h1;
	logic        oe, int_d, int_oe, mrk, rval, ok;
	logic [3:0]  src = 4'h0, sop = 4'h0, good = 4'h0, cmd = 4'h0, lamp;
	logic [7:0]  ad_o, rdat, x, q[$];
	logic [15:0] lfsr = 16'h4a41;
	int          err_count = 0, n_tests = 0, n;
	phy_util_pkg::bus_pins_type pins;
	phy_util_port phy_util_port_i (.MCLK_IN(clk), .RESET_N_IN(rst_n),
		.AD_IN(pins.ad), .AD_OUT(ad_o), .AD_OE_OUT(oe), .ALE_IN(pins.ale),
		.CS_N_IN(pins.cs_n), .RD_N_IN(pins.rd_n), .WR_N_IN(pins.wr_n),
		.INT_N_OUT(int_d), .INT_N_OE_OUT(int_oe), .INT_SOURCE_IN(src),
		.RATE_64_IN(rate), .RX_CELL_START_IN(sop), .RX_GOOD_CELL_IN(good),
		.RX_TIMING_CMD_IN(cmd), .RX_ACTIVITY_LAMP_N_OUT(lamp),
		.RX_TIMING_MARKER_N_OUT(mrk));
	phy_util_host phy_util_host_i (.clk_in(clk), .oe_in(oe), .ad_in(ad_o),
		.pins_out(pins), .rd_data_out(rdat), .rd_valid_out(rval));
	initial forever #2.5 clk = ~clk;
	task end_of_test;
		if (err_count == 0 && n_tests > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_of_test
	task rd(input logic [7:0] a, e);
		q.push_back(e);
		phy_util_host_i.rd(a, ok);
		if (ok !== 1'h1)
		begin
			err_count++;
			end_of_test;
		end
	endtask : rd
	task pin(input logic [3:0] s, g, c, i);
		@(negedge clk);
		{sop, good, cmd, src} = {s, g, c, i};
		@(negedge clk);
		{sop, good, cmd, src} = 16'h0000;
	endtask : pin
	// Counts marker low cycles after a command
	// First sample is the falling edge on which the command is withdrawn
	task lows;
		n = 0;
		repeat (12)
		begin
			n += int'(mrk === 1'h0);
			@(negedge clk);
		end
	endtask : lows
	// One step of the stimulus shift register
	function automatic logic [15:0] lfsr_next(input logic [15:0] v);
		return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
	endfunction : lfsr_next
	always @(posedge clk)
		if (rval)
		begin
			x = q.pop_front();
			`CHK(rdat, x)
		end
	initial
	begin
		repeat (5) @(negedge clk);
		rst_n = 1'h1;
		repeat (5) @(negedge clk);
		rd(8'h40, 8'h00);
		rd(8'h41, 8'h01);
		rd(8'h44, 8'h01);
		rd(8'h66, 8'h00);
		lfsr = lfsr_next(lfsr);
		phy_util_host_i.wr(8'h41, lfsr[7:0], 1'h0);
		rd(8'h41, lfsr[7:0]);
		phy_util_host_i.wr(8'h41, ~lfsr[7:0], 1'h1);
		rd(8'h41, lfsr[7:0]);
		phy_util_host_i.wr(8'h41, 8'h03, 1'h0);
		phy_util_host_i.wr(8'h40, 8'h02, 1'h0);
		pin(4'h0, 4'h0, 4'h2, 4'h0);
		lows;
		`CHK(n, 0)
		pin(4'h0, 4'h0, 4'h4, 4'h0);
		lows;
		`CHK(n, 3)
		pin(4'h8, 4'h0, 4'h0, 4'h0);
		repeat (3) @(negedge clk);
		`CHK(lamp, 4'hf)
		pin(4'h8, 4'h8, 4'h0, 4'h0);
		repeat (200) @(negedge clk);
		`CHK(lamp, 4'h7)
		pin(4'h0, 4'h0, 4'h0, 4'h2);
		repeat (4) @(negedge clk);
		`CHK(int_oe, 1'h0)
		rd(8'h42, 8'h02);
		phy_util_host_i.wr(8'h43, 8'h02, 1'h0);
		rd(8'h43, 8'h02);
		pin(4'h0, 4'h0, 4'h0, 4'h2);
		repeat (30) @(negedge clk);
		`CHK({int_oe, int_d}, 2'h2)
		rd(8'h42, 8'h02);
		`CHK(int_oe, 1'h0)
		// Second reset also takes the 32 MHz strap
		rst_n = 1'h0;
		rate = 1'h0;
		repeat (5) @(negedge clk);
		rst_n = 1'h1;
		repeat (5) @(negedge clk);
		`CHK(lamp, 4'hf)
		rd(8'h43, 8'h00);
		rd(8'h44, 8'h00);
		end_of_test;
	end
endmodule : phy_util_port_tb_top
